/* File: hdl/asb_atomic.sv */
/*
  Conditional-store and memory-barrier execution unit.
  Assumes the pipeline pulses LL_EXEC/EXC_TAKEN, and MEM_IDLE means every
  earlier load has written back and every store is globally visible.
*/
`timescale 1ns/10ps
`default_nettype none

module asb_atomic
  import asb_pkg::*;
(
  input  wire logic           MCLK,
  input  wire logic           RSTN,
  input  wire logic           ISSUE_VALID,
  output logic                ISSUE_READY,
  input  wire asb_pkg::asb_issue_t    ISSUE,
  input  wire logic           LL_EXEC,
  input  wire logic           EXC_TAKEN,
  output asb_pkg::asb_xlat_req_t      XLAT_REQ,
  input  wire asb_pkg::asb_xlat_rsp_t XLAT_RSP,
  output asb_pkg::asb_mem_wr_t        MEM_WR,
  input  wire logic           MEM_WR_ACK,
  output logic                WB_FLUSH,
  output logic                HOLD_LATER,
  input  wire logic           WB_EMPTY,
  input  wire logic           MEM_IDLE,
  output logic                LINK_FLAG,
  output asb_pkg::asb_result_t        RESULT
);
  import asb_pkg::*;

  localparam asb_state_t ST_RST = '0;

  asb_state_t        st_q;
  asb_state_t        st_d;
  logic              take;
  logic              is_sc;
  logic              is_barrier;
  logic [XLEN-1:0]   ea;
  logic              clear_link;

  assign ISSUE_READY = (st_q.fsm == ASB_IDLE);
  assign take        = ISSUE_VALID && ISSUE_READY;
  assign is_sc       = (ISSUE.instr[OPC_HI:OPC_LO] == OPC_STORE_COND);
  // Barrier-type field is not looked at, so types 1-31 act as type 0
  assign is_barrier  = (ISSUE.instr[OPC_HI:OPC_LO] == OPC_FUNC_GROUP)
                    && (ISSUE.instr[FN_HI:FN_LO] == FN_BARRIER);
  assign ea = ISSUE.base_val
            + {{(XLEN-OFF_W){ISSUE.instr[OFF_HI]}}, ISSUE.instr[OFF_HI:OFF_LO]};

  always_comb begin
    st_d       = st_q;
    clear_link = 1'b0;
    st_d.res.valid  = 1'b0;
    st_d.res.gpr_we = 1'b0;
    st_d.res.exc    = ASB_EXC_NONE;
    case (st_q.fsm)
      ASB_IDLE: begin
        if (take) begin
          st_d.res.gpr_idx = ISSUE.instr[TGT_HI:TGT_LO];
          if (is_sc) begin
            st_d.data = ISSUE.target_val;
            if (ea[ALIGN_W-1:0] != ALIGN_OK) begin
              st_d.res.valid = 1'b1;
              st_d.res.exc   = ASB_EXC_ADDR;
              clear_link     = 1'b1;
            end else if (!st_q.link_flag) begin
              // Failing store skips translation so it can fault on nothing
              st_d.res.valid  = 1'b1;
              st_d.res.gpr_we = 1'b1;
              st_d.res.value  = '0;
              clear_link      = 1'b1;
            end else begin
              st_d.xlat.valid = 1'b1;
              st_d.xlat.vaddr = ea;
              st_d.fsm        = ASB_XLAT;
            end
          end else if (is_barrier) begin
            st_d.flush = 1'b1;
            st_d.fsm   = ASB_DRAIN;
          end else begin
            st_d.res.valid = 1'b1;
            st_d.res.exc   = ASB_EXC_RESV;
          end
        end
      end
      ASB_XLAT: begin
        if (XLAT_RSP.valid) begin
          st_d.xlat.valid = 1'b0;
          st_d.fsm        = ASB_IDLE;
          st_d.res.valid  = 1'b1;
          clear_link      = 1'b1;
          if (XLAT_RSP.exc != ASB_EXC_NONE) begin
            st_d.res.exc = XLAT_RSP.exc;
          end else if (!st_q.link_flag) begin
            // Exception taken while translating: sequence is broken
            st_d.res.gpr_we = 1'b1;
            st_d.res.value  = '0;
          end else begin
            st_d.res.valid    = 1'b0;
            clear_link        = 1'b0;
            st_d.mem_wr.valid = 1'b1;
            st_d.mem_wr.paddr = XLAT_RSP.paddr;
            st_d.mem_wr.data  = st_q.data;
            st_d.fsm          = ASB_STORE;
          end
        end
      end
      ASB_STORE: begin
        if (MEM_WR_ACK) begin
          st_d.mem_wr.valid = 1'b0;
          st_d.res.valid    = 1'b1;
          st_d.res.gpr_we   = 1'b1;
          st_d.res.value    = {{(XLEN-1){1'b0}}, 1'b1};
          clear_link        = 1'b1;
          st_d.fsm          = ASB_IDLE;
        end
      end
      ASB_DRAIN: begin
        // Later loads and stores stay held until everything earlier is done
        if (WB_EMPTY && MEM_IDLE) begin
          st_d.flush     = 1'b0;
          st_d.res.valid = 1'b1;
          st_d.fsm       = ASB_IDLE;
        end
      end
      default: begin
        st_d = ST_RST;
      end
    endcase
    if (clear_link || EXC_TAKEN) begin
      st_d.link_flag = 1'b0;
    end
    // A new linked load wins over any clear in the same cycle
    if (LL_EXEC) begin
      st_d.link_flag = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign XLAT_REQ   = st_q.xlat;
  assign MEM_WR     = st_q.mem_wr;
  assign WB_FLUSH   = st_q.flush;
  assign HOLD_LATER = st_q.flush;
  assign LINK_FLAG  = st_q.link_flag;
  assign RESULT     = st_q.res;

  a_misalign_no_store: assert property (@(posedge MCLK) disable iff (!RSTN)
    take && is_sc && (ea[ALIGN_W-1:0] != ALIGN_OK)
    |=> RESULT.valid && (RESULT.exc == ASB_EXC_ADDR) && !RESULT.gpr_we && !MEM_WR.valid)
    else $error("misaligned conditional store not faulted");

  a_unlinked_fails: assert property (@(posedge MCLK) disable iff (!RSTN)
    take && is_sc && (ea[ALIGN_W-1:0] == ALIGN_OK) && !LINK_FLAG
    |=> RESULT.valid && RESULT.gpr_we && (RESULT.value == '0) && !XLAT_REQ.valid)
    else $error("unlinked conditional store did not fail cleanly");

  a_linked_translates: assert property (@(posedge MCLK) disable iff (!RSTN)
    take && is_sc && (ea[ALIGN_W-1:0] == ALIGN_OK) && LINK_FLAG
    |=> XLAT_REQ.valid && (XLAT_REQ.vaddr == $past(ea)))
    else $error("effective address wrong or translation not requested");

  a_store_then_one: assert property (@(posedge MCLK) disable iff (!RSTN)
    MEM_WR.valid && MEM_WR_ACK
    |=> RESULT.valid && RESULT.gpr_we && (RESULT.value == XLEN'(1)) && !MEM_WR.valid
        && (!LINK_FLAG || $past(LL_EXEC)))
    else $error("completed store did not report success");

  a_store_held: assert property (@(posedge MCLK) disable iff (!RSTN)
    MEM_WR.valid && !MEM_WR_ACK |=> MEM_WR.valid && $stable(MEM_WR.data))
    else $error("store request dropped before acknowledge");

  a_result_width: assert property (@(posedge MCLK) disable iff (!RSTN)
    RESULT.valid && RESULT.gpr_we |-> (RESULT.value[XLEN-1:1] == '0))
    else $error("result upper bits not zero");

  a_exc_breaks_link: assert property (@(posedge MCLK) disable iff (!RSTN)
    EXC_TAKEN && !LL_EXEC |=> !LINK_FLAG)
    else $error("exception left link flag set");

  a_ll_sets_link: assert property (@(posedge MCLK) disable iff (!RSTN)
    LL_EXEC |=> LINK_FLAG)
    else $error("linked load did not set link flag");

  a_drain_release: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q.fsm == ASB_DRAIN) && !(WB_EMPTY && MEM_IDLE)
    |=> WB_FLUSH && HOLD_LATER && !RESULT.valid)
    else $error("barrier released before memory drained");

  a_barrier_clean: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q.fsm == ASB_DRAIN) && WB_EMPTY && MEM_IDLE
    |=> RESULT.valid && (RESULT.exc == ASB_EXC_NONE) && !HOLD_LATER && ISSUE_READY)
    else $error("barrier finished badly");

endmodule // asb_atomic

`default_nettype wire

/* File: hdl/asb_pkg.sv */
/*
  Shared types and constants for the conditional-store and memory-barrier unit.
  Assumes a 32-bit datapath and instruction word, one core clock.
*/
package asb_pkg;

  localparam int XLEN    = 32;
  localparam int OFF_W   = 16;
  localparam int GIDX_W  = 5;
  localparam int ALIGN_W = 2;

  // Instruction field positions
  localparam int OPC_HI  = 31;
  localparam int OPC_LO  = 26;
  localparam int BASE_HI = 25;
  localparam int BASE_LO = 21;
  localparam int TGT_HI  = 20;
  localparam int TGT_LO  = 16;
  localparam int OFF_HI  = 15;
  localparam int OFF_LO  = 0;
  localparam int FN_HI   = 5;
  localparam int FN_LO   = 0;

  localparam logic [5:0] OPC_STORE_COND  = 6'h38;
  localparam logic [5:0] OPC_FUNC_GROUP  = 6'h00;
  localparam logic [5:0] FN_BARRIER      = 6'h0F;
  localparam logic [1:0] ALIGN_OK        = 2'h0;

  typedef enum logic [2:0] {
    ASB_EXC_NONE,
    ASB_EXC_ADDR,
    ASB_EXC_TLB_REFILL,
    ASB_EXC_TLB_INVALID,
    ASB_EXC_TLB_MOD,
    ASB_EXC_RESV
  } asb_exc_t;

  typedef enum logic [1:0] {
    ASB_IDLE,
    ASB_XLAT,
    ASB_STORE,
    ASB_DRAIN
  } asb_fsm_t;

  typedef struct packed {
    logic [XLEN-1:0] instr;
    logic [XLEN-1:0] base_val;
    logic [XLEN-1:0] target_val;
  } asb_issue_t;

  typedef struct packed {
    logic            valid;
    logic [XLEN-1:0] vaddr;
  } asb_xlat_req_t;

  typedef struct packed {
    logic            valid;
    asb_exc_t        exc;
    logic [XLEN-1:0] paddr;
  } asb_xlat_rsp_t;

  typedef struct packed {
    logic            valid;
    logic [XLEN-1:0] paddr;
    logic [XLEN-1:0] data;
  } asb_mem_wr_t;

  typedef struct packed {
    logic              valid;
    logic              gpr_we;
    logic [GIDX_W-1:0] gpr_idx;
    logic [XLEN-1:0]   value;
    asb_exc_t          exc;
  } asb_result_t;

  typedef struct packed {
    asb_fsm_t        fsm;
    logic            link_flag;
    logic            flush;
    logic [XLEN-1:0] data;
    asb_xlat_req_t   xlat;
    asb_mem_wr_t     mem_wr;
    asb_result_t     res;
  } asb_state_t;

endpackage

/* File: sim/asb_mem_model.sv */
/*
  Behavioural translation, store and write-buffer side facing the atomic unit.
  Assumes the bench sets latency, fault code and drain time before each operation.
*/
`timescale 1ns/10ps
`default_nettype none

module asb_mem_model
  import asb_pkg::*;
#(
  parameter logic [31:0] PA_OFS = 32'h1000_0000
)(
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire asb_pkg::asb_xlat_req_t xlat_req,
  output asb_pkg::asb_xlat_rsp_t      xlat_rsp,
  input  wire asb_pkg::asb_mem_wr_t   mem_wr,
  output logic                        mem_wr_ack,
  input  wire logic                   wb_flush,
  output logic                        wb_empty,
  output logic                        mem_idle,
  input  wire logic [1:0]             lat,
  input  wire asb_pkg::asb_exc_t      fault,
  input  wire logic [2:0]             drain
);
  logic [3:0] cnt;
  logic       done_x;
  logic       done_w;

  assign done_x = xlat_req.valid && (cnt >= {2'h0, lat});
  assign done_w = mem_wr.valid && (cnt >= {2'h0, lat});
  // Address lines wander while no answer is given
  // One fixed mapping, vaddr plus PA_OFS, for every page
  assign xlat_rsp = '{done_x, fault, done_x ? xlat_req.vaddr + PA_OFS : {8{cnt}}};
  assign mem_wr_ack = done_w;
  // Store visible at once when not flushing; while flushing, only once drain time ran out
  assign wb_empty = !wb_flush || (cnt >= {1'h0, drain});
  assign mem_idle = wb_empty;

  always_ff @(posedge mclk) begin
    if (!rstn || done_x || done_w || !(xlat_req.valid || mem_wr.valid || wb_flush)) begin
      cnt <= 4'h0;
    end else if (cnt != 4'hF) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule // asb_mem_model

`default_nettype wire

/* File: sim/tb_top.sv */
/*
  Self-checking bench for the conditional-store and barrier unit.
  Assumes the memory model above answers every request within a few cycles.
*/
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

module tb_top;
  import asb_pkg::*;
  logic MCLK = 1'b0, RSTN = 1'b0, ISSUE_VALID = 1'b0, LL_EXEC = 1'b0, EXC_TAKEN = 1'b0;
  logic ISSUE_READY, MEM_WR_ACK, WB_FLUSH, HOLD_LATER, WB_EMPTY, MEM_IDLE, LINK_FLAG;
  asb_issue_t    ISSUE = '0;
  asb_xlat_req_t XLAT_REQ;
  asb_xlat_rsp_t XLAT_RSP;
  asb_mem_wr_t   MEM_WR;
  asb_result_t   RESULT, r;
  asb_exc_t      fault = ASB_EXC_NONE;
  logic [1:0]    lat = 2'h0;
  logic [2:0]    drn = 3'h0;
  logic [31:0]   seed = 32'h33a0, b, t, wr_pa, wr_d;
  logic [15:0]   off;
  int n_fail = 0, checks = 0, n_wr = 0, n_hold = 0, cyc = 0, k, w0, h0;

  asb_atomic i_asb_atomic (.MCLK(MCLK), .RSTN(RSTN), .ISSUE_VALID(ISSUE_VALID),
    .ISSUE_READY(ISSUE_READY), .ISSUE(ISSUE), .LL_EXEC(LL_EXEC), .EXC_TAKEN(EXC_TAKEN),
    .XLAT_REQ(XLAT_REQ), .XLAT_RSP(XLAT_RSP), .MEM_WR(MEM_WR), .MEM_WR_ACK(MEM_WR_ACK),
    .WB_FLUSH(WB_FLUSH), .HOLD_LATER(HOLD_LATER), .WB_EMPTY(WB_EMPTY),
    .MEM_IDLE(MEM_IDLE), .LINK_FLAG(LINK_FLAG), .RESULT(RESULT));
  asb_mem_model i_asb_mem_model (.mclk(MCLK), .rstn(RSTN), .xlat_req(XLAT_REQ),
    .xlat_rsp(XLAT_RSP), .mem_wr(MEM_WR), .mem_wr_ack(MEM_WR_ACK), .wb_flush(WB_FLUSH),
    .wb_empty(WB_EMPTY), .mem_idle(MEM_IDLE), .lat(lat), .fault(fault), .drain(drn));

  initial begin
    forever #5 MCLK = ~MCLK;
  end

  always @(posedge MCLK) begin
    cyc++;
    if (MEM_WR.valid === 1'b1 && MEM_WR_ACK === 1'b1) begin
      n_wr++;
      wr_pa = MEM_WR.paddr;
      wr_d = MEM_WR.data;
    end
    if (RSTN) `CHK("hold", WB_FLUSH, HOLD_LATER)
    if (HOLD_LATER === 1'b1) begin
      n_hold++;
    end
    if (cyc > 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] sc_i(input logic [4:0] tg, input logic [15:0] o);
    return {OPC_STORE_COND, 5'h3, tg, o};
  endfunction

  task automatic pulse(input bit ll);
    @(posedge MCLK); #1;
    if (ll) LL_EXEC = 1'b1; else EXC_TAKEN = 1'b1;
    @(posedge MCLK); #1;
    LL_EXEC = 1'b0;
    EXC_TAKEN = 1'b0;
  endtask

  // Offer one instruction, hold it until taken, then catch the one-cycle result
  task automatic run(input logic [31:0] ins, input logic [31:0] bv, input logic [31:0] tv);
    @(posedge MCLK); #1;
    ISSUE_VALID = 1'b1;
    ISSUE = '{ins, bv, tv};
    w0 = n_wr;
    h0 = n_hold;
    while (ISSUE_READY !== 1'b1) begin @(posedge MCLK); #1; end
    @(posedge MCLK); #1;
    ISSUE_VALID = 1'b0;
    k = 0;
    while (RESULT.valid !== 1'b1 && k < 60) begin @(posedge MCLK); #1; k++; end
    r = RESULT;
    `CHK("answered", 1'b1, r.valid)
  endtask

  // Linked or not, aligned or not, with a given translation fault
  task automatic sc_case(input bit lk, input logic [31:0] bv, input logic [15:0] o,
                         input asb_exc_t f);
    logic [31:0] ea;
    logic        ok;
    ea = bv + {{16{o[15]}}, o};
    fault = f;
    lat = 2'($random(seed));
    t = $random(seed);
    if (lk) pulse(1'b1);
    run(sc_i(5'h9, o), bv, t);
    ok = lk && ea[1:0] == 2'h0 && f == ASB_EXC_NONE;
    `CHK("exc", ea[1:0] != 2'h0 ? ASB_EXC_ADDR : (lk ? f : ASB_EXC_NONE), r.exc)
    `CHK("wrote", ok ? w0 + 1 : w0, n_wr)
    if (ok) `CHK("wr_pa", ea + 32'h1000_0000, wr_pa)
    if (ok) `CHK("wr_d", t, wr_d)
    if (r.exc == ASB_EXC_NONE) `CHK("value", {31'h0, ok}, r.value)
    if (r.exc == ASB_EXC_NONE) `CHK("idx", 5'h9, r.gpr_idx)
    `CHK("link", 1'b0, LINK_FLAG)
  endtask

  initial begin
    repeat (16) @(posedge MCLK);
    #1 RSTN = 1'b1;
    sc_case(1'b0, 32'h0000_0100, 16'h0010, ASB_EXC_NONE);
    sc_case(1'b1, 32'h0000_0100, 16'hFFF0, ASB_EXC_NONE);
    sc_case(1'b1, 32'h0000_0102, 16'h0001, ASB_EXC_NONE);
    for (int i = 2; i < 5; i++) sc_case(1'b1, 32'h0000_2000, 16'h0004, asb_exc_t'(i));
    // Linked load and exception in one cycle: the set wins
    @(posedge MCLK); #1;
    LL_EXEC = 1'b1;
    EXC_TAKEN = 1'b1;
    @(posedge MCLK); #1;
    LL_EXEC = 1'b0;
    EXC_TAKEN = 1'b0;
    `CHK("ll_wins", 1'b1, LINK_FLAG)
    pulse(1'b0);
    `CHK("exc_clr", 1'b0, LINK_FLAG)
    sc_case(1'b0, 32'h0000_0200, 16'h0000, ASB_EXC_NONE);
    // Exception lands while translation is still pending
    pulse(1'b1);
    lat = 2'h3;
    fault = ASB_EXC_NONE;
    fork
      run(sc_i(5'h9, 16'h0000), 32'h0000_0400, 32'h5A5A_5A5A);
      begin
        @(posedge MCLK);
        pulse(1'b0);
      end
    join
    `CHK("late_exc", 32'h0, r.value)
    `CHK("late_we", 1'b1, r.gpr_we)
    `CHK("late_wr", w0, n_wr)
    pulse(1'b1);
    @(posedge MCLK); #1 RSTN = 1'b0;
    @(posedge MCLK); #1 RSTN = 1'b1;
    sc_case(1'b0, 32'h0000_0300, 16'h0008, ASB_EXC_NONE);
    run(32'hFC00_0000, 32'h0, 32'h0);
    `CHK("resv", ASB_EXC_RESV, r.exc)
    `CHK("resv_we", 1'b0, r.gpr_we)
    for (int s = 0; s < 32; s += 31) begin
      drn = 3'($random(seed));
      run({OPC_FUNC_GROUP, 15'h0, 5'(s), FN_BARRIER}, 32'h0, 32'h0);
      `CHK("bar_exc", ASB_EXC_NONE, r.exc)
      `CHK("bar_we", 1'b0, r.gpr_we)
      `CHK("bar_wait", 1'b1, k > int'(drn))
      `CHK("bar_rel", 1'b0, WB_FLUSH)
      `CHK("bar_hold", h0 + int'(drn) + 1, n_hold)
    end
    for (int i = 0; i < 24; i++) begin
      b = $random(seed);
      off = 16'($random(seed));
      sc_case(1'($random(seed)), b, off, ASB_EXC_NONE);
    end
    tally_and_finish();
  end

  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
endmodule // tb_top

`default_nettype wire
